// ===== hdl/acc_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          converter control block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// ==========================================================================
// Register byte offsets
`define ACC_ADDR_W        8
`define ACC_OFF_CTRL      8'h00
`define ACC_OFF_SRCCLK    8'h04
`define ACC_OFF_REFAMP    8'h08
`define ACC_OFF_BANDGAP   8'h0C
`define ACC_OFF_RES_LO    8'h10
`define ACC_OFF_RES_HI    8'h14
`define ACC_OFF_INT_STAT  8'h18
`define ACC_OFF_INT_MASK  8'h1C

// ==========================================================================
// Field positions of conv_control and source_clock_select, write masks of the reference amp and bandgap
`define ACC_CTRL_START    7
`define ACC_CTRL_BUSY     6
`define ACC_CTRL_EN       5
`define ACC_CTRL_ALIGN    4
`define ACC_SRC_LSB       4
`define ACC_DIV_LSB       0
`define ACC_REFAMP_MASK   8'h9F
`define ACC_BANDGAP_MASK  8'h01

// ==========================================================================
// Reset values, last external channel and timing counts in conversion clock ticks
`define ACC_RST_BYTE      8'h00
`define ACC_RST_RESULT    12'h000
`define ACC_EXT_LAST      4'h8
`define ACC_SAMPLE_TICKS  4'h4
`define ACC_BIT_TICKS     4'h6

`endif

// ===== hdl/acc_pkg.sv
// Purpose: Types of the converter control block.
// Assumes: Constants come from acc_cfg.svh.
// Notes:   Holds no numbers of its own beyond field widths and state codes.
package acc_pkg;

  typedef enum logic [1:0] {
    ACC_IDLE   = 2'b00,
    ACC_SAMPLE = 2'b01,
    ACC_BITS   = 2'b10
  } acc_state_e;

  // Controls toward the analog converter core and input multiplexer.
  typedef struct packed {
    logic        conv_enable;
    logic        sample;
    logic [11:0] dac_code;
    logic [8:0]  ext_select;
    logic [3:0]  input_source_select;
    logic        ref_amp_enable;
    logic        ref_amp_input_select;
    logic [1:0]  reference_select;
    logic [1:0]  ref_amp_gain_select;
    logic        bandgap_enable;
  } acc_analog_s;

  // Digital function and pull-high enables of the shared analog pins.
  typedef struct packed {
    logic [8:0] digital_en;
    logic [8:0] pullup_en;
  } acc_pins_s;

  typedef struct packed {
    logic        start;
    logic        enable;
    logic        align;
    logic [3:0]  ext_ch;
    logic [3:0]  src_sel;
    logic [2:0]  clk_div;
    logic [7:0]  refamp;
    logic        bandgap;
    logic        busy;
    logic [11:0] result;
    logic        int_status;
    logic        int_mask;
    acc_state_e  fsm;
    logic [6:0]  div_cnt;
    logic [3:0]  step_cnt;
    logic [3:0]  bit_idx;
    logic [11:0] sar;
    logic [2:0]  cmp_sync;
    logic        cmp_filt;
    logic [31:0] prdata;
    acc_analog_s ana;
    acc_pins_s   pins;
  } acc_state_s;

endpackage : acc_pkg

// ===== hdl/acc_top.sv
// Purpose: Control, sequencing and result logic of a 12-bit successive
//          approximation converter, reached over APB.
// Assumes: The analog core offers a comparator output that is high when
//          the selected input is above the DAC code.
// Notes:
// Operation
// - a conversion starts when software writes start high, then low.
// - completing the start sequence sets the busy flag.
// - busy clears when the conversion has finished.
// - busy is read only; writes do not change it.
// - enable must be high to convert; low powers the converter down.
// - while disabled, both result bytes keep their contents.
// - alignment low: high byte holds D11..D4, low byte D3..D0 on top.
// - alignment high: high byte holds D11..D8 low, low byte D7..D0.
// - result bit positions not holding data read as zero.
// - each conversion gives an unsigned 12-bit result.
// - channel codes 0 to 8 pick external inputs 0 to 8.
// - channel codes above 8 connect no input.
// - an internal source disconnects the external channel.
// - analog pins lose digital function and pull-high resistor.
// - source codes map to external, supply fractions, amp or ground.
// - clock field divides system clock by 1 up to 128.
`timescale 1ns/1ps
`default_nettype none
`include "acc_cfg.svh"

module acc_top (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`ACC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Interrupt
  output logic                         irq,
  // Analog core and multiplexer
  input  wire logic                    cmp_hi,
  output acc_pkg::acc_analog_s         analog_ctrl,
  // Shared pins
  input  wire logic [8:0]              pin_analog_cfg,
  input  wire logic [8:0]              pin_pullup_req,
  output acc_pkg::acc_pins_s           pin_ctrl
);

  acc_pkg::acc_state_s st;
  acc_pkg::acc_state_s next_st;

  logic                   setup;
  logic                   access;
  logic                   wr;
  logic                   mapped;
  logic                   wr_ctrl;
  logic                   start_go;
  logic [6:0]             div_limit;
  logic                   tick;
  logic                   step_done;
  logic                   finish;
  logic                   src_ext;
  logic [7:0]             res_lo;
  logic [7:0]             res_hi;
  logic [7:0]             rd_byte;

  // ========================================================================
  // APB decode
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= `ACC_OFF_INT_MASK);
  assign wr_ctrl = wr && (paddr == `ACC_OFF_CTRL);
  assign pready  = access;
  assign pslverr = access & ~mapped;
  assign prdata  = st.prdata;
  assign irq     = st.int_status & st.int_mask;

  // A start counts on the falling write of the start bit.
  assign start_go = wr_ctrl && st.start && !pwdata[`ACC_CTRL_START]
                    && pwdata[`ACC_CTRL_EN] && !st.busy;

  // ========================================================================
  // Conversion clock divider and sequencing
  assign div_limit = 7'((8'h01 << st.clk_div) - 8'h01);
  assign tick      = (st.div_cnt >= div_limit);
  assign step_done = tick && (st.step_cnt == `ACC_BIT_TICKS - 4'h1);
  assign finish    = (st.fsm == acc_pkg::ACC_BITS) && step_done
                     && (st.bit_idx == 4'h0);

  // External when 0000, 0100 or 11xx; everything else is internal.
  assign src_ext = ((st.src_sel[1:0] == 2'b00) && (st.src_sel[3:2] != 2'b10))
                   || (st.src_sel[3:2] == 2'b11);

  // ========================================================================
  // Result formatting
  always_comb begin
    if (st.align) begin
      res_hi = {4'h0, st.result[11:8]};
      res_lo = st.result[7:0];
    end else begin
      res_hi = st.result[11:4];
      res_lo = {st.result[3:0], 4'h0};
    end
  end

  always_comb begin
    if (paddr == `ACC_OFF_CTRL) begin
      rd_byte = {st.start, st.busy, st.enable, st.align, st.ext_ch};
    end else if (paddr == `ACC_OFF_SRCCLK) begin
      rd_byte = {st.src_sel, 1'b0, st.clk_div};
    end else if (paddr == `ACC_OFF_REFAMP) begin
      rd_byte = st.refamp;
    end else if (paddr == `ACC_OFF_BANDGAP) begin
      rd_byte = {7'h00, st.bandgap};
    end else if (paddr == `ACC_OFF_RES_LO) begin
      rd_byte = res_lo;
    end else if (paddr == `ACC_OFF_RES_HI) begin
      rd_byte = res_hi;
    end else if (paddr == `ACC_OFF_INT_STAT) begin
      rd_byte = {7'h00, st.int_status};
    end else if (paddr == `ACC_OFF_INT_MASK) begin
      rd_byte = {7'h00, st.int_mask};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // ========================================================================
  // Next state
  always_comb begin
    next_st = st;
    // Read data is captured in the setup phase and stands in the access.
    if (setup) begin
      next_st.prdata = {24'h000000, rd_byte};
    end
    if (wr_ctrl) begin
      next_st.start  = pwdata[`ACC_CTRL_START];
      next_st.enable = pwdata[`ACC_CTRL_EN];
      next_st.align  = pwdata[`ACC_CTRL_ALIGN];
      next_st.ext_ch = pwdata[3:0];
    end
    if (wr && (paddr == `ACC_OFF_SRCCLK)) begin
      next_st.src_sel = pwdata[`ACC_SRC_LSB +: 4];
      next_st.clk_div = pwdata[`ACC_DIV_LSB +: 3];
    end
    if (wr && (paddr == `ACC_OFF_REFAMP)) begin
      next_st.refamp = pwdata[7:0] & `ACC_REFAMP_MASK;
    end
    if (wr && (paddr == `ACC_OFF_BANDGAP)) begin
      next_st.bandgap = pwdata[0];
    end
    if (wr && (paddr == `ACC_OFF_INT_MASK)) begin
      next_st.int_mask = pwdata[0];
    end
    if (wr && (paddr == `ACC_OFF_INT_STAT) && pwdata[0]) begin
      next_st.int_status = 1'b0;
    end

    // Comparator: three flops, accepted once the last two agree.
    next_st.cmp_sync = {st.cmp_sync[1:0], cmp_hi};
    if (st.cmp_sync[1] == st.cmp_sync[2]) begin
      next_st.cmp_filt = st.cmp_sync[2];
    end

    next_st.div_cnt = tick ? 7'h00 : 7'(st.div_cnt + 7'h01);

    case (st.fsm)
      acc_pkg::ACC_IDLE: begin
        next_st.step_cnt = 4'h0;
        if (start_go) begin
          next_st.busy    = 1'b1;
          next_st.fsm     = acc_pkg::ACC_SAMPLE;
          next_st.div_cnt = 7'h00;
        end
      end
      acc_pkg::ACC_SAMPLE: begin
        if (tick) begin
          next_st.step_cnt = 4'(st.step_cnt + 4'h1);
        end
        if (tick && (st.step_cnt == `ACC_SAMPLE_TICKS - 4'h1)) begin
          next_st.fsm      = acc_pkg::ACC_BITS;
          next_st.step_cnt = 4'h0;
          next_st.bit_idx  = 4'hB;
          next_st.sar      = 12'h800;
        end
      end
      acc_pkg::ACC_BITS: begin
        if (tick) begin
          next_st.step_cnt = 4'(st.step_cnt + 4'h1);
        end
        if (step_done) begin
          // Keep or drop the trial bit, then try the next lower one.
          next_st.step_cnt             = 4'h0;
          next_st.sar[st.bit_idx]      = st.cmp_filt;
          if (st.bit_idx != 4'h0) begin
            next_st.sar[st.bit_idx - 4'h1] = 1'b1;
            next_st.bit_idx = 4'(st.bit_idx - 4'h1);
          end
        end
        if (finish) begin
          next_st.result = next_st.sar;
          next_st.busy   = 1'b0;
          next_st.fsm    = acc_pkg::ACC_IDLE;
          next_st.int_status = 1'b1;
        end
      end
      default: begin
        next_st.fsm = acc_pkg::ACC_IDLE;
      end
    endcase

    // Disabling aborts a conversion; the result bytes are left alone.
    if (!next_st.enable) begin
      next_st.fsm    = acc_pkg::ACC_IDLE;
      next_st.busy   = 1'b0;
      next_st.result = st.result;
    end

    // Analog side controls.
    next_st.ana.conv_enable = st.enable;
    next_st.ana.sample      = (st.fsm == acc_pkg::ACC_SAMPLE);
    next_st.ana.dac_code    = st.sar;
    next_st.ana.input_source_select = st.src_sel;
    next_st.ana.ext_select  = 9'h000;
    if (src_ext && (st.ext_ch <= `ACC_EXT_LAST)) begin
      next_st.ana.ext_select = 9'(10'h001 << st.ext_ch);
    end
    next_st.ana.ref_amp_enable       = st.refamp[7];
    next_st.ana.ref_amp_input_select = st.refamp[4];
    next_st.ana.reference_select     = st.refamp[3:2];
    next_st.ana.ref_amp_gain_select  = st.refamp[1:0];
    next_st.ana.bandgap_enable       = st.bandgap;
    next_st.pins.digital_en = ~pin_analog_cfg;
    next_st.pins.pullup_en  = pin_pullup_req & ~pin_analog_cfg;
  end

  // ========================================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign analog_ctrl = st.ana;
  assign pin_ctrl    = st.pins;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_busy_set;
    start_go |=> st.busy;
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy not set after start sequence");

  property p_busy_clear;
    finish |=> !st.busy && st.int_status;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy not cleared at conversion end");

  property p_busy_ro;
    (wr_ctrl && !start_go && !finish && pwdata[`ACC_CTRL_EN])
      |=> st.busy == $past(st.busy);
  endproperty
  a_busy_ro: assert property (p_busy_ro)
    else $error("write changed busy flag");

  property p_hold_off;
    !st.enable |=> st.result == $past(st.result);
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("result changed while disabled");

  property p_result_edge;
    st.result != $past(st.result) |-> $fell(st.busy);
  endproperty
  a_result_edge: assert property (p_result_edge)
    else $error("result changed without completion");

  property p_align_lo;
    setup && !st.align && (paddr == `ACC_OFF_RES_LO)
      |=> prdata[3:0] == 4'h0 && prdata[7:4] == $past(st.result[3:0]);
  endproperty
  a_align_lo: assert property (p_align_lo)
    else $error("low byte misaligned");

  property p_align_hi;
    setup && st.align && (paddr == `ACC_OFF_RES_HI)
      |=> prdata[7:0] == {4'h0, $past(st.result[11:8])};
  endproperty
  a_align_hi: assert property (p_align_hi)
    else $error("high byte misaligned");

  property p_ext_off;
    (!src_ext || st.ext_ch > `ACC_EXT_LAST) |=> analog_ctrl.ext_select == 0;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("external input connected");

  property p_ext_sel;
    (src_ext && st.ext_ch <= `ACC_EXT_LAST)
      |=> $onehot(analog_ctrl.ext_select)
          && analog_ctrl.ext_select[$past(st.ext_ch)];
  endproperty
  a_ext_sel: assert property (p_ext_sel)
    else $error("selected external input not connected");

  property p_pin_free;
    (pin_analog_cfg != 9'h000)
      |=> ((pin_ctrl.digital_en | pin_ctrl.pullup_en)
           & $past(pin_analog_cfg)) == 9'h000;
  endproperty
  a_pin_free: assert property (p_pin_free)
    else $error("analog pin keeps digital function or pull-high");

  property p_ignore;
    (wr_ctrl && st.busy) |=> st.fsm != acc_pkg::ACC_SAMPLE
                              || $past(st.fsm) == acc_pkg::ACC_SAMPLE;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("start accepted while busy");

  property p_div1;
    (st.clk_div == 3'h0) |-> tick;
  endproperty
  a_div1: assert property (p_div1)
    else $error("undivided clock not ticking");

  c_finish: cover property (finish);
  c_abort: cover property (st.busy ##1 !st.enable);
  c_irq: cover property (irq);
  c_refused: cover property (wr_ctrl && st.busy);
  c_div_max: cover property (finish && st.clk_div == 3'h7);

endmodule : acc_top

`default_nettype wire

// ===== tb/acc_analog_model.sv
// Purpose: Analog sources behind the converter input multiplexer.
// Assumes: Each source sits half an LSB above its nominal code.
// Notes:   An open input gives a comparator that flips every cycle.
`timescale 1ns/1ps
`default_nettype none

module acc_analog_model #(
  parameter logic [11:0] AMP_LVL = 12'hC00
) (
  // Clock
  input  wire logic                 ref_clk,
  // Converter side
  input  wire acc_pkg::acc_analog_s analog_ctrl,
  input  wire logic [107:0]         ext_lvl,
  output logic                      cmp_hi
);
  logic [11:0] lvl;
  logic        live;
  logic        flt = 1'b0;

  // ====================
  // Source selection
  always_comb begin
    live = 1'b1;
    lvl  = 12'h000;
    case (analog_ctrl.input_source_select)
      4'h1: lvl = 12'hFFF;
      4'h2: lvl = 12'h800;
      4'h3: lvl = 12'h400;
      4'h5: lvl = AMP_LVL;
      4'h6: lvl = AMP_LVL >> 1;
      4'h7: lvl = AMP_LVL >> 2;
      4'h8, 4'h9, 4'hA, 4'hB: lvl = 12'h000;
      default: begin
        live = 1'b0;
        for (int i = 0; i < 9; i++) begin
          if (analog_ctrl.ext_select[i]) begin
            lvl  = ext_lvl[i*12 +: 12];
            live = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    flt <= ~flt;
  end

  assign cmp_hi = live ? ({lvl, 1'b1} > {analog_ctrl.dac_code, 1'b0}) : flt;
endmodule : acc_analog_model

`default_nettype wire

// ===== tb/test_adc_conversion_control.sv
// Purpose: Self-checking bench of the converter control block.
// Assumes: Zero wait state APB slave, divider code d gives 76 << d cycles.
// Notes:   Poll reads add a few cycles to every measured duration.
`timescale 1ns/1ps
`default_nettype none
`include "acc_cfg.svh"

module test_adc_conversion_control;
  logic                 ref_clk, rst_n, psel, penable, pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 pready, pslverr, irq, cmp_hi, err;
  acc_pkg::acc_analog_s analog_ctrl;
  acc_pkg::acc_pins_s   pin_ctrl;
  logic [8:0]           pin_analog_cfg, pin_pullup_req;
  logic [107:0]         ext_lvl;
  int                   bad_count, checked, cycles;

  acc_top acc_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .cmp_hi(cmp_hi), .analog_ctrl(analog_ctrl),
    .pin_analog_cfg(pin_analog_cfg), .pin_pullup_req(pin_pullup_req),
    .pin_ctrl(pin_ctrl));

  acc_analog_model acc_analog_model_inst (.ref_clk(ref_clk),
    .analog_ctrl(analog_ctrl), .ext_lvl(ext_lvl), .cmp_hi(cmp_hi));

  // ====================
  // Clock and timeout
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  // ====================
  // Helpers
  function automatic logic [11:0] lvl(input int n);
    return 12'(12'h13B * (n + 1));
  endfunction : lvl

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic res(input logic al, input logic [11:0] v);
    apb(1'b0, `ACC_OFF_RES_HI, 8'h00);
    chk(rd, al ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
    apb(1'b0, `ACC_OFF_RES_LO, 8'h00);
    chk(rd, al ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
  endtask : res

  // ====================
  // Scenarios
  task automatic regs();
    apb(1'b0, `ACC_OFF_CTRL, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, `ACC_OFF_SRCCLK, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, `ACC_OFF_REFAMP, 8'hFF);
    apb(1'b0, `ACC_OFF_REFAMP, 8'h00);
    chk(rd, 32'h9F);
    apb(1'b1, `ACC_OFF_BANDGAP, 8'hFF);
    apb(1'b0, `ACC_OFF_BANDGAP, 8'h00);
    chk(rd, 32'h01);
    chk(analog_ctrl[6:0], 32'h7F);
    apb(1'b1, `ACC_OFF_CTRL, 8'h40);
    apb(1'b0, `ACC_OFF_CTRL, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, 8'h20, 8'hFF);
    chk(err, 1'b1);
    apb(1'b0, 8'h20, 8'h00);
    chk({rd[31:1], err}, 32'h1);
  endtask : regs

  task automatic mux();
    for (int c = 0; c < 10; c++) begin
      apb(1'b1, `ACC_OFF_CTRL, 8'(c));
      repeat (3) @(posedge ref_clk);
      chk(analog_ctrl.ext_select, c < 9 ? 32'h1 << c : 32'h0);
    end
    for (int s = 0; s < 16; s++) begin
      apb(1'b1, `ACC_OFF_SRCCLK, {4'(s), 4'h0});
      apb(1'b1, `ACC_OFF_CTRL, 8'h03);
      repeat (3) @(posedge ref_clk);
      chk(analog_ctrl.input_source_select, 32'(s));
      chk(analog_ctrl.ext_select, (s == 0 || s == 4 || s > 11) ? 32'h8 : 32'h0);
    end
  endtask : mux

  task automatic pins();
    pin_analog_cfg <= 9'h0A5;
    pin_pullup_req <= 9'h1F3;
    repeat (3) @(posedge ref_clk);
    chk(pin_ctrl.digital_en, 32'h15A);
    chk(pin_ctrl.pullup_en, 32'h152);
  endtask : pins

  task automatic conv(input logic [7:0] c, input logic [3:0] s,
                      input logic [2:0] dv, input logic again,
                      input logic [11:0] v);
    int t0;
    int lo;
    lo = 76 << dv;
    apb(1'b1, `ACC_OFF_SRCCLK, {s, 1'b0, dv});
    apb(1'b1, `ACC_OFF_CTRL, c | 8'hA0);
    apb(1'b1, `ACC_OFF_CTRL, c | 8'h20);
    t0 = cycles;
    apb(1'b0, `ACC_OFF_CTRL, 8'h00);
    chk(rd[6], 32'h1);
    chk(analog_ctrl.sample, 32'h1);
    if (again) begin
      repeat (30) @(posedge ref_clk);
      apb(1'b1, `ACC_OFF_CTRL, c | 8'hA0);
      apb(1'b1, `ACC_OFF_CTRL, c | 8'h20);
    end
    do apb(1'b0, `ACC_OFF_CTRL, 8'h00);
    while (rd[6] === 1'b1);
    chk(cycles - t0 >= lo && cycles - t0 <= lo + 8, 32'h1);
    chk(analog_ctrl.dac_code, v);
    res(c[4], v);
    apb(1'b1, `ACC_OFF_CTRL, (c | 8'h20) ^ 8'h10);
    res(~c[4], v);
  endtask : conv

  task automatic intr();
    apb(1'b0, `ACC_OFF_INT_STAT, 8'h00);
    chk(rd, 32'h1);
    chk(irq, 32'h0);
    apb(1'b1, `ACC_OFF_INT_MASK, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk(irq, 32'h1);
    apb(1'b1, `ACC_OFF_INT_STAT, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk(irq, 32'h0);
    apb(1'b0, `ACC_OFF_INT_STAT, 8'h00);
    chk(rd, 32'h0);
  endtask : intr

  task automatic off(input logic [11:0] v);
    // Start a full-scale conversion and disable it 23 cycles into its 76.
    apb(1'b1, `ACC_OFF_SRCCLK, 8'h10);
    apb(1'b1, `ACC_OFF_CTRL, 8'hA0);
    apb(1'b1, `ACC_OFF_CTRL, 8'h20);
    repeat (20) @(posedge ref_clk);
    apb(1'b1, `ACC_OFF_CTRL, 8'h00);
    apb(1'b1, `ACC_OFF_CTRL, 8'h80);
    apb(1'b1, `ACC_OFF_CTRL, 8'h00);
    repeat (100) @(posedge ref_clk);
    apb(1'b0, `ACC_OFF_CTRL, 8'h00);
    chk(rd, 32'h0);
    chk(analog_ctrl.conv_enable, 32'h0);
    res(1'b0, v);
  endtask : off

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ====================
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_analog_cfg, pin_pullup_req} = '0;
    {bad_count, checked, cycles} = '0;
    for (int n = 0; n < 9; n++) ext_lvl[n*12 +: 12] = lvl(n);
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    regs();
    mux();
    pins();
    conv(8'h03, 4'h0, 3'd0, 1'b1, lvl(3));
    intr();
    conv(8'h18, 4'h0, 3'd2, 1'b0, lvl(8));
    conv(8'h03, 4'h1, 3'd0, 1'b0, 12'hFFF);
    conv(8'h03, 4'h6, 3'd0, 1'b0, 12'h600);
    conv(8'h03, 4'hA, 3'd7, 1'b0, 12'h000);
    conv(8'h05, 4'hC, 3'd1, 1'b0, lvl(5));
    off(lvl(5));
    results();
  end
endmodule : test_adc_conversion_control

`default_nettype wire
